/* inc/urx_pkg.sv */
// Purpose: Constants for the low-power serial receive block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: Offsets are byte addresses
package urx_pkg;
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] STAT_OFS = 6'h04;
  localparam logic [5:0] IEN_OFS = 6'h08;
  localparam logic [5:0] IFL_OFS = 6'h0c;
  localparam logic [5:0] DIV_OFS = 6'h10;
  localparam logic [5:0] OSR_OFS = 6'h14;
  localparam logic [5:0] FIFO_OFS = 6'h20;
  localparam logic [5:0] WKEN_OFS = 6'h34;
  localparam logic [5:0] WKFL_OFS = 6'h38;
  localparam logic [5:0] TXLV_OFS = 6'h3c;
  // Control bit positions
  localparam int THD_LSB = 0;
  localparam int PAR_EN_BIT = 4;
  localparam int PAR_ODD_BIT = 5;
  localparam int PAR_ZERO_BIT = 6;
  localparam int CTS_DIS_BIT = 7;
  localparam int FLOW_BIT = 13;
  localparam int BCLK_ON_BIT = 15;
  localparam int EDGE_CHK_BIT = 18;
  localparam int READY_BIT = 19;
  localparam int HALF_BIT = 21;
  localparam int BOTH_EDGE_BIT = 22;
  // Flag bit positions
  localparam int FL_FERR = 0;
  localparam int FL_PAR = 1;
  localparam int FL_CTS = 2;
  localparam int FL_OV = 3;
  localparam int FL_THD = 4;
  localparam int FL_HE = 5;
  localparam int FL_AE = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_0080;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [2:0] OSR_RST = 3'h5;
  localparam logic [15:0] FULL_SAMPLE_LIMIT = 16'h0010;
  localparam int SETTLE_CYC = 4;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage : urx_pkg

/* hw/urx_core.sv */
// Purpose: Serial receiver with events, baud divider and wake logic
// Assumes: One clock mclk_in; serial and cts pins asynchronous
// Notes: Frame is 8 data bits, 1 stop bit, optional parity
// Function
// - Low-power strict mode: three samples per data bit must all agree.
// - Strict: start low, data equal, stop high, parity equal expected.
// - Parity counts ones or zeros; odd selects odd-count high.
// - A frame with a frame error is not stored.
// - Outside strict mode, parity mismatch sets its flag; character still stored.
// - CTS change flagged only with flow control and baud clock on.
// - Valid frame into full FIFO is dropped; overrun set at stop end.
// - Threshold event when stored frame makes level exceed threshold.
// - Transmit half-empty when level goes from half plus one to half.
// - Transmit almost-empty when exactly one byte remains.
// - Flags stick until written one; interrupt needs enable.
// - Port inactive while clock off, settling, or after divisor write.
// - Bit value from three samples around bit middle.
// - Divisor below sixteen forces full sampling every cycle, except half-step mode with an odd divisor.
// - One baud clock: source divided by divisor.
// - Half-step mode counts divisor in half steps.
// - Half-step oversample codes 0..4 give 8,12,16,20,24.
// - Both-edge sampling option for low-power reception.
// - Standard instance never sets wake flags; they are set only in half-step mode.
// - Low-power instance stores valid frames in deep sleep.
// - Three wake flags: threshold, full, not empty.
// - Normal mode: two of three data samples decide; no data error.
`timescale 1ns/100ps
`default_nettype none
module urx_core #(
  parameter int DEPTH = 8,
  parameter bit LOW_POWER = 1'b1
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic deep_sleep_in,
  input wire logic serial_rx_in,
  input wire logic cts_in,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq_out,
  output logic wake_out
);
  typedef enum logic [2:0] {URX_IDLE, URX_START, URX_DATA, URX_PAR, URX_STOP} urx_state_e;
  localparam int LW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // Register state
  logic [31:0] ctrl_q;
  logic [15:0] div_q;
  logic [2:0] osr_q;
  logic [6:0] ien_q, ifl_q;
  logic [2:0] wken_q, wkfl_q;
  logic [LW-1:0] txlv_q, rxlv_q;
  logic [7:0] mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] wp_q, rp_q;
  logic [3:0] settle_q;

  // AXI write capture and response registers
  logic aw_q, w_q;
  logic [5:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic bv_q, rv_q;
  logic [1:0] br_q, rr_q;
  logic [31:0] rd_q;

  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  wire wr_go = aw_q && w_q && !bv_q;
  wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  wire [31:0] wv = wd_q & wmask;
  wire wr_ctrl = wr_go && awa_q == urx_pkg::CTRL_OFS;
  wire wr_div = wr_go && awa_q == urx_pkg::DIV_OFS;
  wire wr_osr = wr_go && awa_q == urx_pkg::OSR_OFS;
  wire wr_ien = wr_go && awa_q == urx_pkg::IEN_OFS;
  wire wr_ifl = wr_go && awa_q == urx_pkg::IFL_OFS;
  wire wr_wken = wr_go && awa_q == urx_pkg::WKEN_OFS;
  wire wr_wkfl = wr_go && awa_q == urx_pkg::WKFL_OFS;
  wire wr_txlv = wr_go && awa_q == urx_pkg::TXLV_OFS;
  wire wr_ok = wr_ctrl | wr_div | wr_osr | wr_ien | wr_ifl | wr_wken | wr_wkfl | wr_txlv;
  wire rd_go = s_axi_arvalid && !rv_q;
  wire rd_fifo = rd_go && s_axi_araddr == urx_pkg::FIFO_OFS;

  // Control fields
  wire bclk_on = ctrl_q[urx_pkg::BCLK_ON_BIT];
  wire half_mode = LOW_POWER && ctrl_q[urx_pkg::HALF_BIT];
  wire strict = half_mode && ctrl_q[urx_pkg::EDGE_CHK_BIT];
  wire both_edge = LOW_POWER && ctrl_q[urx_pkg::BOTH_EDGE_BIT];
  wire par_en = ctrl_q[urx_pkg::PAR_EN_BIT];
  wire [3:0] thd = ctrl_q[urx_pkg::THD_LSB +: 4];
  wire ready = bclk_on && settle_q == 4'(urx_pkg::SETTLE_CYC);
  // Inactive while clock off or settling; divisor writes restart settling
  wire active = ready;
  // Standard instance cannot run in deep sleep
  wire run = active && (LOW_POWER || !deep_sleep_in);

  // Settling counter
  always_ff @(posedge mclk_in) begin
    if (rst_in || !bclk_on || ((wr_div || wr_osr) && bclk_on)) begin
      settle_q <= 4'h0;
    end else if (settle_q != 4'(urx_pkg::SETTLE_CYC)) begin
      settle_q <= settle_q + 4'h1;
    end
  end

  // Pin synchronisers, three stages
  logic [2:0] rx_s_q, cts_s_q;
  logic rx_v_q, cts_v_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rx_s_q <= 3'h7;
      cts_s_q <= 3'h0;
      rx_v_q <= 1'b1;
      cts_v_q <= 1'b0;
    end else begin
      rx_s_q <= {rx_s_q[1:0], serial_rx_in};
      cts_s_q <= {cts_s_q[1:0], cts_in};
      if (rx_s_q[1] == rx_s_q[2]) rx_v_q <= rx_s_q[2];
      if (cts_s_q[1] == cts_s_q[2]) cts_v_q <= cts_s_q[2];
    end
  end

  // Falling-edge sample for both-edge mode
  logic rx_n_q;
  always_ff @(negedge mclk_in) begin
    if (rst_in) rx_n_q <= 1'b1;
    else rx_n_q <= rx_s_q[2];
  end
  wire rx_bit = both_edge ? (rx_v_q & rx_n_q) | (rx_v_q & rx_s_q[2]) : rx_v_q;

  // Samples per bit
  function automatic logic [15:0] urx_osr_f(input logic [2:0] c, input logic h);
    if (h) urx_osr_f = 16'h8 + 16'(c) * 16'h4;
    else urx_osr_f = 16'h8 << c;
  endfunction
  wire full_samp = div_q < urx_pkg::FULL_SAMPLE_LIMIT;
  wire [15:0] nsamp = full_samp ? (half_mode ? {1'b0, div_q[15:1]} : div_q)
                                : urx_osr_f(osr_q, half_mode);
  // Sample tick: divisor over samples; half-step halves the count
  wire [15:0] eff_div = half_mode ? {1'b0, div_q[15:1]} : div_q;
  wire [15:0] tick_per = full_samp ? 16'h1 : (eff_div / urx_osr_f(osr_q, half_mode));
  logic [15:0] tcnt_q;
  logic half_q;
  wire tick = run && tcnt_q == 16'h0;
  always_ff @(posedge mclk_in) begin
    if (rst_in || !run) begin
      tcnt_q <= 16'h0;
      half_q <= 1'b0;
    end else if (tcnt_q == 16'h0) begin
      half_q <= half_mode && div_q[0] && !half_q;
      tcnt_q <= (tick_per == 16'h0) ? 16'h0 : tick_per - 16'h1 + 16'(half_q);
    end else begin
      tcnt_q <= tcnt_q - 16'h1;
    end
  end

  // Receiver
  urx_state_e st_q;
  logic [15:0] sc_q;
  logic [2:0] bi_q, smp_q;
  logic [7:0] sh_q;
  logic err_q, perr_q;
  wire [15:0] mid = {1'b0, nsamp[15:1]};
  wire at_s0 = sc_q == mid - 16'h1;
  wire at_s1 = sc_q == mid;
  wire at_s2 = sc_q == mid + 16'h1;
  wire bit_end = sc_q >= nsamp - 16'h1;
  wire [2:0] smp3 = {rx_bit, smp_q[1:0]};
  wire maj = (smp3[0] & smp3[1]) | (smp3[1] & smp3[2]) | (smp3[0] & smp3[2]);
  wire all_eq = &smp3 | ~|smp3;
  // Expected parity
  wire [3:0] ones = 4'(sh_q[0]) + 4'(sh_q[1]) + 4'(sh_q[2]) + 4'(sh_q[3])
                  + 4'(sh_q[4]) + 4'(sh_q[5]) + 4'(sh_q[6]) + 4'(sh_q[7]);
  wire [3:0] cnt = ctrl_q[urx_pkg::PAR_ZERO_BIT] ? 4'h8 - ones : ones;
  wire exp_par = ctrl_q[urx_pkg::PAR_ODD_BIT] ? cnt[0] : !cnt[0];
  logic fin_q, fok_q;
  wire full = rxlv_q == LW'(DEPTH);

  always_ff @(posedge mclk_in) begin
    if (rst_in || !run) begin
      st_q <= URX_IDLE;
      sc_q <= 16'h0;
      bi_q <= 3'h0;
      smp_q <= 3'h0;
      sh_q <= 8'h0;
      err_q <= 1'b0;
      perr_q <= 1'b0;
      fin_q <= 1'b0;
      fok_q <= 1'b0;
    end else begin
      fin_q <= 1'b0;
      if (tick) begin
        sc_q <= sc_q + 16'h1;
        if (at_s0) smp_q[0] <= rx_bit;
        if (at_s1) smp_q[1] <= rx_bit;
        if (at_s2) begin
          unique case (st_q)
            URX_START: if (|smp3) err_q <= 1'b1;
            URX_DATA: begin
              sh_q <= {maj, sh_q[7:1]};
              if (strict ? !all_eq : !(&smp3 | ~|smp3 | 1'b1) ) err_q <= 1'b1;
            end
            URX_PAR: begin
              if (!(&smp3 | ~|smp3)) err_q <= 1'b1;
              if (strict && smp3 != {3{exp_par}}) err_q <= 1'b1;
              perr_q <= maj != exp_par;
            end
            URX_STOP: if (!(&smp3)) err_q <= 1'b1;
            default: ;
          endcase
        end
        if (st_q == URX_IDLE) begin
          sc_q <= 16'h0;
          err_q <= 1'b0;
          perr_q <= 1'b0;
          if (!rx_bit) st_q <= URX_START;
        end else if (bit_end) begin
          sc_q <= 16'h0;
          unique case (st_q)
            URX_START: st_q <= URX_DATA;
            URX_DATA: begin
              bi_q <= bi_q + 3'h1;
              if (bi_q == 3'h7) st_q <= par_en ? URX_PAR : URX_STOP;
            end
            URX_PAR: st_q <= URX_STOP;
            URX_STOP: begin
              st_q <= URX_IDLE;
              fin_q <= 1'b1;
              fok_q <= !err_q;
            end
            default: st_q <= URX_IDLE;
          endcase
        end
      end
    end
  end

  // Normal mode data error: majority covers any pattern of three bits
  wire store = fin_q && fok_q && !full;
  wire ovr = fin_q && fok_q && full;
  wire ferr = fin_q && !fok_q;
  wire pev = store && perr_q && par_en;
  wire [LW-1:0] lv_next = rxlv_q + LW'(store) - LW'(rd_fifo && rxlv_q != '0);
  wire thd_ev = store && lv_next > LW'(thd) && rxlv_q <= LW'(thd);
  logic cts_p_q;
  logic [LW-1:0] txold_q;
  wire he_ev = txold_q == LW'(DEPTH / 2 + 1) && txlv_q == LW'(DEPTH / 2);
  wire ae_ev = txold_q != LW'(1) && txlv_q == LW'(1);
  wire cts_ev = ctrl_q[urx_pkg::FLOW_BIT] && bclk_on && cts_v_q != cts_p_q;
  wire [6:0] ev = {ae_ev, he_ev, thd_ev, ovr, cts_ev, pev, ferr};
  // Wake conditions
  wire [2:0] wk_ev = {rxlv_q != '0, full, rxlv_q >= LW'(thd) && thd != 4'h0};

  // FIFO and level
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wp_q <= '0;
      rp_q <= '0;
      rxlv_q <= '0;
    end else begin
      if (store) begin
        mem_q[wp_q] <= sh_q;
        wp_q <= wp_q + PW'(1);
      end
      if (rd_fifo && rxlv_q != '0) rp_q <= rp_q + PW'(1);
      rxlv_q <= lv_next;
    end
  end

  // Registers and flags
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_q <= urx_pkg::CTRL_RST;
      div_q <= urx_pkg::DIV_RST;
      osr_q <= urx_pkg::OSR_RST;
      ien_q <= 7'h0;
      ifl_q <= 7'h0;
      wken_q <= 3'h0;
      wkfl_q <= 3'h0;
      txlv_q <= '0;
      txold_q <= '0;
      cts_p_q <= 1'b0;
    end else begin
      cts_p_q <= cts_v_q;
      txold_q <= txlv_q;
      if (wr_ctrl) ctrl_q <= wv & ~(32'h1 << urx_pkg::READY_BIT);
      if (wr_div) div_q <= wv[15:0];
      if (wr_osr) osr_q <= wv[2:0];
      if (wr_ien) ien_q <= wv[6:0];
      if (wr_txlv) txlv_q <= wv[LW-1:0];
      if (wr_wken) wken_q <= wv[2:0];
      // Set wins over write-one clear
      ifl_q <= (ifl_q & ~(wr_ifl ? wv[6:0] : 7'h0)) | ev;
      wkfl_q <= (wkfl_q & ~(wr_wkfl ? wv[2:0] : 3'h0)) | (half_mode ? wk_ev : 3'h0);
    end
  end
  assign irq_out = |(ifl_q & ien_q);
  assign wake_out = |(wkfl_q & wken_q);

  // AXI channel handling
  wire [31:0] rmux = s_axi_araddr == urx_pkg::CTRL_OFS ?
                       (ctrl_q | (32'(ready) << urx_pkg::READY_BIT)) :
                     s_axi_araddr == urx_pkg::STAT_OFS ? 32'(rxlv_q) :
                     s_axi_araddr == urx_pkg::IEN_OFS ? 32'(ien_q) :
                     s_axi_araddr == urx_pkg::IFL_OFS ? 32'(ifl_q) :
                     s_axi_araddr == urx_pkg::DIV_OFS ? 32'(div_q) :
                     s_axi_araddr == urx_pkg::OSR_OFS ? 32'(osr_q) :
                     s_axi_araddr == urx_pkg::FIFO_OFS ? 32'(mem_q[rp_q]) :
                     s_axi_araddr == urx_pkg::WKEN_OFS ? 32'(wken_q) :
                     s_axi_araddr == urx_pkg::WKFL_OFS ? 32'(wkfl_q) :
                     s_axi_araddr == urx_pkg::TXLV_OFS ? 32'(txlv_q) : 32'h0;
  wire rd_ok = s_axi_araddr == urx_pkg::CTRL_OFS || s_axi_araddr == urx_pkg::STAT_OFS
            || s_axi_araddr == urx_pkg::IEN_OFS || s_axi_araddr == urx_pkg::IFL_OFS
            || s_axi_araddr == urx_pkg::DIV_OFS || s_axi_araddr == urx_pkg::OSR_OFS
            || s_axi_araddr == urx_pkg::FIFO_OFS || s_axi_araddr == urx_pkg::WKEN_OFS
            || s_axi_araddr == urx_pkg::WKFL_OFS || s_axi_araddr == urx_pkg::TXLV_OFS;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 6'h0;
      wd_q <= 32'h0;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= urx_pkg::AXI_OKAY;
      rv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= urx_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= wr_ok ? urx_pkg::AXI_OKAY : urx_pkg::AXI_SLVERR;
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
      end
      if (rd_go) begin
        rv_q <= 1'b1;
        rd_q <= rmux;
        rr_q <= rd_ok ? urx_pkg::AXI_OKAY : urx_pkg::AXI_SLVERR;
      end else if (rv_q && s_axi_rready) begin
        rv_q <= 1'b0;
      end
    end
  end
endmodule : urx_core
`default_nettype wire

/* dv/urx_chk.sv */
// Purpose: Port checks for the serial receive block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to urx_core below
`timescale 1ns/100ps
`default_nettype none
module urx_chk (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic irq_out,
  input wire logic wake_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == urx_pkg::AXI_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read with data");
  reset_quiet_a: assert property ($fell(rst_in) |-> !irq_out && !wake_out)
    else $error("outputs high after reset");
  irq_keep_a: assert property ($fell(irq_out) |-> s_axi_bvalid)
    else $error("irq dropped without write");
  wake_keep_a: assert property ($fell(wake_out) |-> s_axi_bvalid)
    else $error("wake dropped without write");
endmodule : urx_chk
bind urx_core urx_chk u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .irq_out(irq_out), .wake_out(wake_out));
`default_nettype wire

/* dv/urx_peer.sv */
// Purpose: Far-end serial transmitter model
// Assumes: Frame bits given first bit in bit 0, line idles high
// Notes: Bit period counted in clock cycles
`timescale 1ns/100ps
`default_nettype none
module urx_peer (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic send_in,
  input wire logic [10:0] bits_in,
  input wire logic [3:0] count_in,
  input wire logic [7:0] period_in,
  output logic line_out,
  output logic busy_out
);
  logic [10:0] sh_q;
  logic [3:0] left_q;
  logic [7:0] cnt_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      line_out <= 1'b1;
      busy_out <= 1'b0;
    end else if (!busy_out && send_in) begin
      sh_q <= bits_in;
      left_q <= count_in;
      cnt_q <= period_in - 8'h1;
      busy_out <= 1'b1;
      line_out <= bits_in[0];
    end else if (busy_out && cnt_q != 8'h0) begin
      cnt_q <= cnt_q - 8'h1;
    end else if (busy_out && left_q == 4'h1) begin
      busy_out <= 1'b0;
      line_out <= 1'b1;
    end else if (busy_out) begin
      sh_q <= sh_q >> 1;
      left_q <= left_q - 4'h1;
      cnt_q <= period_in - 8'h1;
      line_out <= sh_q[1];
    end
  end
endmodule : urx_peer
`default_nettype wire

/* dv/urx_core_bench.sv */
// Purpose: Self-checking bench for the serial receive block
// Assumes: Full sampling with divisor below sixteen
// Notes: Random bytes from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module urx_core_bench;
  logic clk, rst, ds, rx, cts, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, irq, wake, snd, busy;
  logic [5:0] awa, ara;
  logic [31:0] wd, rdata, rd, on;
  logic [1:0] bresp, rresp, rsp, wrs;
  logic [10:0] fb;
  logic [3:0] fc;
  logic [7:0] per, b;
  logic [7:0] q[$];
  logic [3:0] tl[6] = '{4'h6, 4'h4, 4'h5, 4'h4, 4'h2, 4'h1};
  int err_count, cmp_count, cyc;
  urx_core #(.DEPTH(8), .LOW_POWER(1'b1)) u_dut (.mclk_in(clk), .rst_in(rst),
    .deep_sleep_in(ds), .serial_rx_in(rx), .cts_in(cts), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .irq_out(irq), .wake_out(wake));
  urx_peer u_peer (.mclk_in(clk), .rst_in(rst), .send_in(snd), .bits_in(fb), .count_in(fc),
    .period_in(per), .line_out(rx), .busy_out(busy));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk);
      cyc++;
      if (cyc == 30000) begin
        err_count++;
        test_done();
      end
    end
  end
  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv && br;
      if (tb) wrs = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
  endtask : axw
  task automatic axr(input logic [5:0] a);
    logic ta, tr;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv && rr;
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end
  endtask : axr
  task automatic pins(input logic ei, input logic ew);
    @(negedge clk);
    chk("irq", {31'h0, ei}, {31'h0, irq});
    chk("wake", {31'h0, ew}, {31'h0, wake});
    @(posedge clk);
  endtask : pins
  function automatic logic [10:0] frame(input logic [7:0] d, input logic pe, input logic odd,
      input logic zer, input logic bad, input logic stp);
    logic [3:0] n;
    n = zer ? 4'(8 - $countones(d)) : 4'($countones(d));
    return pe ? {stp, (odd ? n[0] : ~n[0]) ^ bad, d, 1'b0} : {1'b1, stp, d, 1'b0};
  endfunction : frame
  task automatic send(input logic [10:0] f, input logic pe, input logic [7:0] p);
    fb <= f;
    fc <= pe ? 4'hb : 4'ha;
    per <= p;
    snd <= 1'b1;
    @(posedge clk);
    snd <= 1'b0;
    do @(negedge clk); while (busy);
    repeat (3 * int'(p)) @(posedge clk);
  endtask : send
  task automatic setup(input logic [31:0] c, input logic [15:0] dv);
    axw(urx_pkg::CTRL_OFS, c);
    axr(urx_pkg::CTRL_OFS);
    chk("ready off", 32'h0, {31'h0, rd[urx_pkg::READY_BIT]});
    axw(urx_pkg::DIV_OFS, {16'h0, dv});
    axw(urx_pkg::CTRL_OFS, c | on);
    rd = 32'h0;
    while (rd[urx_pkg::READY_BIT] !== 1'b1) axr(urx_pkg::CTRL_OFS);
  endtask : setup
  initial begin
    {rst, ds, cts, awv, wv, br, arv, rr, snd} = 9'h100;
    {awa, ara, wd, fb, fc, per} = '0;
    err_count = 0;
    cmp_count = 0;
    on = 32'h1 << urx_pkg::BCLK_ON_BIT;
    b = 8'($urandom(32'h92c1e6c4));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(urx_pkg::CTRL_OFS);
    chk("ctrl reset", urx_pkg::CTRL_RST, rd);
    axr(urx_pkg::DIV_OFS);
    chk("div reset", {16'h0, urx_pkg::DIV_RST}, rd);
    axr(urx_pkg::OSR_OFS);
    chk("osr reset", {29'h0, urx_pkg::OSR_RST}, rd);
    axr(6'h2c);
    chk("unmapped resp", {30'h0, urx_pkg::AXI_SLVERR}, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
    axw(6'h2c, 32'h0);
    chk("unmapped wr resp", {30'h0, urx_pkg::AXI_SLVERR}, {30'h0, wrs});
    send(frame(b, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1), 1'b0, 8'h0a);
    axr(urx_pkg::STAT_OFS);
    chk("level clock off", 32'h0, rd);
    axw(urx_pkg::OSR_OFS, 32'($urandom_range(4)));
    setup(32'h2, 16'h000a);
    axw(urx_pkg::IEN_OFS, 32'h1 << urx_pkg::FL_OV);
    chk("wr resp", {30'h0, urx_pkg::AXI_OKAY}, {30'h0, wrs});
    for (int i = 0; i < 9; i++) begin
      b = 8'($urandom);
      send(frame(b, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1), 1'b0, 8'h0a);
      if (i < 8) q.push_back(b);
      axr(urx_pkg::IFL_OFS);
      chk("thd flag", {31'h0, i > 1}, {31'h0, rd[urx_pkg::FL_THD]});
      chk("ovr flag", {31'h0, i == 8}, {31'h0, rd[urx_pkg::FL_OV]});
    end
    axr(urx_pkg::STAT_OFS);
    chk("level full", 32'h8, rd);
    pins(1'b1, 1'b0);
    axw(urx_pkg::IFL_OFS, 32'h7f);
    pins(1'b0, 1'b0);
    while (q.size() > 0) begin
      axr(urx_pkg::FIFO_OFS);
      chk("rx data", {24'h0, q.pop_front()}, rd);
    end
    for (int m = 0; m < 4; m++) begin
      axw(urx_pkg::CTRL_OFS, on | (32'h1 << urx_pkg::PAR_EN_BIT) |
        (32'(m) << urx_pkg::PAR_ODD_BIT));
      for (int k = 0; k < 2; k++) begin
        b = 8'($urandom);
        send(frame(b, 1'b1, m[0], m[1], k[0], 1'b1), 1'b1, 8'h0a);
        axr(urx_pkg::IFL_OFS);
        chk("par flag", {31'h0, k[0]}, {31'h0, rd[urx_pkg::FL_PAR]});
        axr(urx_pkg::FIFO_OFS);
        chk("par data", {24'h0, b}, rd);
        axw(urx_pkg::IFL_OFS, 32'h7f);
      end
    end
    send(frame(b, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1, 8'h0a);
    axr(urx_pkg::IFL_OFS);
    chk("frame err", 32'h1, {31'h0, rd[urx_pkg::FL_FERR]});
    axr(urx_pkg::STAT_OFS);
    chk("frame err level", 32'h0, rd);
    axw(urx_pkg::IFL_OFS, 32'h7f);
    for (int f = 0; f < 2; f++) begin
      axw(urx_pkg::CTRL_OFS, on | (32'(f) << urx_pkg::FLOW_BIT));
      cts <= ~cts;
      repeat (10) @(posedge clk);
      axr(urx_pkg::IFL_OFS);
      chk("cts flag", {31'h0, f[0]}, {31'h0, rd[urx_pkg::FL_CTS]});
    end
    axw(urx_pkg::IFL_OFS, 32'h7f);
    foreach (tl[i]) begin
      axw(urx_pkg::TXLV_OFS, {28'h0, tl[i]});
      axr(urx_pkg::IFL_OFS);
      chk("tx half", {31'h0, i > 2}, {31'h0, rd[urx_pkg::FL_HE]});
      chk("tx almost", {31'h0, i == 5}, {31'h0, rd[urx_pkg::FL_AE]});
    end
    axw(urx_pkg::CTRL_OFS, 32'h0);
    axw(urx_pkg::WKFL_OFS, 32'h7);
    axw(urx_pkg::WKEN_OFS, 32'h4);
    setup((32'h1 << urx_pkg::HALF_BIT) | (32'h1 << urx_pkg::BOTH_EDGE_BIT) |
      (32'h1 << urx_pkg::EDGE_CHK_BIT), 16'h000c);
    ds <= 1'b1;
    pins(1'b0, 1'b0);
    b = 8'($urandom);
    send(frame(b, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1), 1'b0, 8'h06);
    pins(1'b0, 1'b1);
    axr(urx_pkg::WKFL_OFS);
    chk("wake nonempty", 32'h1, {31'h0, rd[2]});
    axr(urx_pkg::FIFO_OFS);
    chk("sleep data", {24'h0, b}, rd);
    pins(1'b0, 1'b1);
    axw(urx_pkg::WKFL_OFS, 32'h7);
    pins(1'b0, 1'b0);
    test_done();
  end
endmodule : urx_core_bench
`default_nettype wire
